// >>> verilog/pso_port.sv
`timescale 1ns/100ps
// Summary of operation
// - Top two packet bits: 00 good, 01, 11
// - Already read since last cycle gives 10
// - Read before first measurement returns stale
// - Continuous mode with either output type; sleep mode only with two-wire output
// - Commands: start measurement, read data
// - Two-wire target address is 0x28
// - Configuration fixed at factory, not writable
// - In two-wire mode pin signals ready
// - Serial link is read-only, no commands
module pso_port #(
    parameter int STARTUP_CYC = pso_pkg::STARTUP_CYC,
    parameter int UPD0_CYC    = pso_pkg::UPD_RATE0_CYC,
    parameter int UPD1_CYC    = pso_pkg::UPD_RATE1_CYC,
    parameter int UPD2_CYC    = pso_pkg::UPD_RATE2_CYC,
    parameter int UPD3_CYC    = pso_pkg::UPD_RATE3_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        cfg_use_tw,
    input  wire logic        cfg_sleep,
    input  wire logic [1:0]  cfg_rate,
    input  wire logic        cmd_mode_in,
    input  wire logic        diag_in,
    output logic             meas_start,
    input  wire logic        meas_done,
    input  wire logic [29:0] meas_value,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             miso_out,
    output logic             miso_oe,
    input  wire logic        int_ss_in,
    output logic             int_ss_out,
    output logic             int_ss_oe,
    output logic [1:0]       status
);
    import pso_pkg::*;

    pso_tw_if tw ();

    logic        cfg_taken;
    logic        use_tw;
    logic        sleep_mode;
    logic [1:0]  rate;
    logic [31:0] boot_cnt;
    logic        booted;
    logic [31:0] per_cnt;
    logic        meas_pend;
    logic        busy;
    logic        first_done;
    logic        fresh;
    logic [29:0] data_reg;
    logic [31:0] pkt_snap;
    logic [2:0]  ss_s;
    logic [2:0]  sclk_s;
    logic        ss_f;
    logic        sclk_f;
    logic        ss_p;
    logic        sclk_p;
    logic [4:0]  bit_ix;
    logic        spi_byte;
    logic        spi_done;

    wire [31:0] period   = (rate == 2'h0) ? 32'(UPD0_CYC) :
                           (rate == 2'h1) ? 32'(UPD1_CYC) :
                           (rate == 2'h2) ? 32'(UPD2_CYC) : 32'(UPD3_CYC);
    wire        per_hit  = booted && !sleep_mode && per_cnt == period - 32'h1;
    wire        go       = booted && meas_pend && !busy;
    wire        spi_act  = cfg_taken && !use_tw && !ss_f;
    wire        spi_beg  = cfg_taken && !use_tw && ss_p && !ss_f;
    wire        spi_end  = cfg_taken && !use_tw && !ss_p && ss_f;
    wire        sclk_fal = spi_act && sclk_p && !sclk_f;
    wire        rd_done  = tw.rd_done || spi_done;
    // Command mode only reachable over the two-wire bus
    wire        cmd_md   = cmd_mode_in && use_tw;
    wire [1:0]  next_st  = diag_in ? ST_DIAG :
                           cmd_md  ? ST_CMD  :
                           fresh   ? ST_GOOD : ST_STALE;

    assign tw.pkt     = pkt_snap;
    assign miso_oe    = spi_act;
    // Shared pin is a ready output only in two-wire mode
    assign int_ss_oe  = cfg_taken && use_tw;
    assign int_ss_out = fresh;

    pso_tw_target u_tw (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (cfg_taken && use_tw),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .tw       (tw.tgt)
    );

    // Straps are caught once after reset and then locked
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cfg_taken  <= 1'b0;
            use_tw     <= 1'b0;
            sleep_mode <= 1'b0;
            rate       <= 2'h0;
        end else if (!cfg_taken) begin
            cfg_taken  <= 1'b1;
            use_tw     <= cfg_use_tw;
            sleep_mode <= cfg_sleep;
            rate       <= cfg_rate;
        end
    end

    // No conversion starts inside the start-up interval
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            boot_cnt <= 32'h0;
            booted   <= 1'b0;
        end else if (!booted) begin
            boot_cnt <= boot_cnt + 32'h1;
            booted   <= boot_cnt == 32'(STARTUP_CYC) - 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            per_cnt <= 32'h0;
        end else if (!booted || sleep_mode || per_hit) begin
            per_cnt <= 32'h0;
        end else begin
            per_cnt <= per_cnt + 32'h1;
        end
    end

    // Update mode triggers at boot and every period; sleep mode on request
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            meas_pend  <= 1'b0;
            busy       <= 1'b0;
            meas_start <= 1'b0;
        end else begin
            meas_start <= go;
            if ((booted && !sleep_mode && (per_hit || !first_done && !busy))
                || (tw.mr_cmd && sleep_mode && booted))
                meas_pend <= 1'b1;
            else if (go)
                meas_pend <= 1'b0;
            if (go)
                busy <= 1'b1;
            else if (meas_done)
                busy <= 1'b0;
        end
    end

    // A new result beats a read that ends in the same cycle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            first_done <= 1'b0;
            fresh      <= 1'b0;
            data_reg   <= 30'h0;
        end else begin
            if (meas_done && busy) begin
                first_done <= 1'b1;
                fresh      <= 1'b1;
                data_reg   <= meas_value;
            end else if (rd_done) begin
                fresh <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            status   <= ST_STALE;
            pkt_snap <= 32'h0;
        end else begin
            status <= next_st;
            if (tw.rd_start || spi_beg)
                pkt_snap <= {next_st, data_reg};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ss_s   <= 3'h7;
            sclk_s <= 3'h0;
            ss_f   <= 1'b1;
            sclk_f <= 1'b0;
            ss_p   <= 1'b1;
            sclk_p <= 1'b0;
        end else begin
            ss_s   <= {ss_s[1:0], int_ss_in};
            sclk_s <= {sclk_s[1:0], scl_in};
            ss_p   <= ss_f;
            sclk_p <= sclk_f;
            if (ss_s[2] == ss_s[1]) ss_f <= ss_s[2];
            if (sclk_s[2] == sclk_s[1]) sclk_f <= sclk_s[2];
        end
    end

    // Serial link shifts out on falling clock, host samples on rising
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bit_ix   <= 5'h0;
            spi_byte <= 1'b0;
            spi_done <= 1'b0;
            miso_out <= 1'b0;
        end else begin
            spi_done <= spi_end && spi_byte;
            miso_out <= pkt_snap[~bit_ix];
            if (spi_beg) begin
                bit_ix   <= 5'h0;
                spi_byte <= 1'b0;
            end else if (sclk_fal) begin
                bit_ix <= bit_ix + 5'h1;
                if (bit_ix == 5'h7) spi_byte <= 1'b1;
            end
        end
    end
endmodule // pso_port

// >>> verilog/pso_pkg.sv
package pso_pkg;
    localparam int          CLK_PERIOD_NS = 5;
    // Least time, so the cycle count rounds up
    localparam int          STARTUP_MS    = 10;
    localparam int          STARTUP_CYC   =
        (STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Update periods per rate code, in ns
    localparam int          UPD_RATE0_NS  = 500000;
    localparam int          UPD_RATE1_NS  = 1500000;
    localparam int          UPD_RATE2_NS  = 5000000;
    localparam int          UPD_RATE3_NS  = 10000000;
    localparam int          UPD_RATE0_CYC = UPD_RATE0_NS / CLK_PERIOD_NS;
    localparam int          UPD_RATE1_CYC = UPD_RATE1_NS / CLK_PERIOD_NS;
    localparam int          UPD_RATE2_CYC = UPD_RATE2_NS / CLK_PERIOD_NS;
    localparam int          UPD_RATE3_CYC = UPD_RATE3_NS / CLK_PERIOD_NS;

    localparam logic [6:0]  TGT_ADDR      = 7'h28;
    localparam int          PKT_W         = 32;
    localparam int          DATA_W        = 30;
    localparam int          STAT_HI       = 31;
    localparam int          STAT_LO       = 30;

    localparam logic [1:0]  ST_GOOD       = 2'h0;
    localparam logic [1:0]  ST_CMD        = 2'h1;
    localparam logic [1:0]  ST_STALE      = 2'h2;
    localparam logic [1:0]  ST_DIAG       = 2'h3;

    typedef enum logic [6:0] {
        TW_IDLE = 7'h01,
        TW_ADDR = 7'h02,
        TW_AACK = 7'h04,
        TW_WR   = 7'h08,
        TW_WACK = 7'h10,
        TW_RD   = 7'h20,
        TW_RACK = 7'h40
    } pso_tw_state_t;

    // Byte ix of the packet, ix 0 being the most significant
    function automatic logic [7:0] pkt_byte(input logic [31:0] p,
                                            input logic [1:0]  ix);
        logic [4:0] sh;
        sh = {~ix, 3'h0};
        return 8'(p >> sh);
    endfunction
endpackage

// >>> verilog/pso_tw_if.sv
`timescale 1ns/100ps
interface pso_tw_if;
    import pso_pkg::*;
    logic [31:0] pkt;
    logic        rd_start;
    logic        rd_done;
    logic        mr_cmd;

    modport tgt  (input pkt, output rd_start, output rd_done, output mr_cmd);
    modport core (output pkt, input rd_start, input rd_done, input mr_cmd);
endinterface

// >>> verilog/pso_tw_target.sv
`timescale 1ns/100ps
module pso_tw_target (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    pso_tw_if.tgt     tw
);
    import pso_pkg::*;

    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic          scl_f;
    logic          sda_f;
    logic          scl_p;
    logic          sda_p;
    pso_tw_state_t state;
    logic [7:0]    shreg;
    logic [2:0]    cnt;
    logic [1:0]    byte_ix;
    logic          is_wr;
    logic          sent;
    logic          got_ack;
    logic          drv;

    wire       scl_rise = scl_f & ~scl_p;
    wire       scl_fall = ~scl_f & scl_p;
    wire       start    = sda_p & ~sda_f & scl_f & scl_p;
    wire       stop     = ~sda_p & sda_f & scl_f & scl_p;
    wire [7:0] addr_rw  = {shreg[6:0], sda_f};
    wire [7:0] cur_byte = pkt_byte(tw.pkt, byte_ix);

    assign sda_out = 1'b0;
    assign sda_oe  = drv;

    // A change counts once the second and third stage agree
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            scl_p <= scl_f;
            sda_p <= sda_f;
            if (scl_s[2] == scl_s[1]) scl_f <= scl_s[2];
            if (sda_s[2] == sda_s[1]) sda_f <= sda_s[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state       <= TW_IDLE;
            shreg       <= 8'h00;
            cnt         <= 3'h0;
            byte_ix     <= 2'h0;
            is_wr       <= 1'b0;
            sent        <= 1'b0;
            got_ack     <= 1'b0;
            drv         <= 1'b0;
            tw.rd_start <= 1'b0;
            tw.rd_done  <= 1'b0;
            tw.mr_cmd   <= 1'b0;
        end else begin
            tw.rd_start <= 1'b0;
            tw.rd_done  <= 1'b0;
            tw.mr_cmd   <= 1'b0;
            if (!en) begin
                state <= TW_IDLE;
                drv   <= 1'b0;
            end else if (start || stop) begin
                // A write addressed to us ends as a measurement request
                tw.mr_cmd  <= stop & is_wr;
                tw.rd_done <= stop & sent;
                state      <= start ? TW_ADDR : TW_IDLE;
                cnt        <= 3'h0;
                drv        <= 1'b0;
                is_wr      <= 1'b0;
                sent       <= 1'b0;
                got_ack    <= 1'b0;
            end else begin
                case (state)
                    TW_ADDR: if (scl_rise) begin
                        shreg <= addr_rw;
                        cnt   <= cnt + 3'h1;
                        if (cnt == 3'h7) begin
                            if (addr_rw[7:1] == TGT_ADDR) begin
                                state       <= TW_AACK;
                                is_wr       <= ~addr_rw[0];
                                tw.rd_start <= addr_rw[0];
                                byte_ix     <= 2'h0;
                            end else begin
                                state <= TW_IDLE;
                            end
                        end
                    end
                    TW_AACK, TW_WACK: if (scl_fall) begin
                        drv <= ~drv;
                        cnt <= 3'h0;
                        if (drv && is_wr) begin
                            state <= TW_WR;
                        end else if (drv) begin
                            // Most significant byte first
                            state   <= TW_RD;
                            shreg   <= cur_byte;
                            drv     <= ~cur_byte[7];
                            byte_ix <= byte_ix + 2'h1;
                        end
                    end
                    TW_WR: if (scl_rise) begin
                        cnt <= cnt + 3'h1;
                        if (cnt == 3'h7) state <= TW_WACK;
                    end
                    TW_RD: if (scl_fall) begin
                        cnt   <= cnt + 3'h1;
                        shreg <= {shreg[6:0], 1'b0};
                        drv   <= ~shreg[6];
                        if (cnt == 3'h7) begin
                            state <= TW_RACK;
                            drv   <= 1'b0;
                            sent  <= 1'b1;
                        end
                    end
                    TW_RACK: begin
                        if (scl_rise) begin
                            if (sda_f) state <= TW_IDLE;
                            got_ack <= ~sda_f;
                        end else if (scl_fall && got_ack) begin
                            got_ack <= 1'b0;
                            state   <= TW_RD;
                            cnt     <= 3'h0;
                            shreg   <= cur_byte;
                            drv     <= ~cur_byte[7];
                            byte_ix <= byte_ix + 2'h1;
                        end
                    end
                    default: state <= TW_IDLE;
                endcase
            end
        end
    end
endmodule // pso_tw_target

// >>> tb/pso_port_asserts.sv
`timescale 1ns/100ps
module pso_port_asserts
    import pso_pkg::*;
#(
    parameter int STARTUP_CYC = 50
) (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       diag_in,
    input wire logic       cmd_mode_in,
    input wire logic       meas_start,
    input wire logic       meas_done,
    input wire logic       int_ss_out,
    input wire logic       int_ss_oe,
    input wire logic       miso_oe,
    input wire logic       sda_oe,
    input wire logic [1:0] status
);
    import pso_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    int boot_cnt;
    always_ff @(posedge core_clk) begin
        if (!resetn)
            boot_cnt <= 0;
        else if (boot_cnt < STARTUP_CYC)
            boot_cnt <= boot_cnt + 1;
    end
    a_diag_wins: assert property (
        diag_in[*8] |-> status == ST_DIAG) else $error("diag code missing");
    a_cmd_code: assert property (
        (cmd_mode_in && !diag_in && int_ss_oe)[*8] |-> status == ST_CMD)
        else $error("command code missing");
    a_fresh_good: assert property (
        (int_ss_out && int_ss_oe && !diag_in && !cmd_mode_in)[*8]
        |-> status == ST_GOOD) else $error("good code missing");
    a_stale_code: assert property (
        (!int_ss_out && int_ss_oe && !diag_in && !cmd_mode_in)[*8]
        |-> status == ST_STALE) else $error("stale code missing");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    a_ready_cause: assert property (
        $rose(int_ss_out) && int_ss_oe
        |-> $past(meas_done) || $past(meas_done, 2) || $past(meas_done, 3))
        else $error("ready rose without a finished measurement");
    a_serial_only: assert property (
        miso_oe |-> !sda_oe && !int_ss_oe)
        else $error("two-wire pins active in serial mode");
    a_boot_quiet: assert property (
        meas_start |-> boot_cnt >= STARTUP_CYC - 1)
        else $error("measurement during start-up");
    c_start: cover property (meas_start);
    c_ready: cover property ($rose(int_ss_out));
    c_serial: cover property (miso_oe);
    c_diag: cover property (status == ST_DIAG);
endmodule // pso_port_asserts

bind pso_port pso_port_asserts #(.STARTUP_CYC(STARTUP_CYC)) u_pso_port_asserts (
    .core_clk(core_clk), .resetn(resetn), .diag_in(diag_in),
    .cmd_mode_in(cmd_mode_in), .meas_start(meas_start),
    .meas_done(meas_done), .int_ss_out(int_ss_out), .int_ss_oe(int_ss_oe),
    .miso_oe(miso_oe), .sda_oe(sda_oe), .status(status));

// >>> tb/pso_host_model.sv
`timescale 1ns/100ps
// Host only ever pulls SDA low; the pull-up gives the high level
module pso_host_model #(
    parameter int HALF = 250 // 400 kHz bus at 200 MHz
) (
    input  wire logic core_clk,
    input  wire logic sda_wire,
    input  wire logic miso,
    output logic      scl,
    output logic      sda_low,
    output logic      ss_n
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
        ss_n    = 1'b1;
    end
    task automatic tick();
        repeat (HALF / 2) @(negedge core_clk);
    endtask
    task automatic hstart();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic hstop();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
    endtask
    task automatic hbit(input logic b, output logic r);
        sda_low = ~b;
        tick();
        scl = 1'b1;
        tick();
        r = sda_wire;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic xfer(input logic [7:0] d, input logic nack,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            hbit(d[i], q[i]);
        end
        hbit(nack, a);
    endtask
    // Serial clock idles low and stands still outside frames
    task automatic sread(output logic [31:0] q);
        // Park the clock low first so the frame opens on a quiet clock
        scl  = 1'b0;
        tick();
        ss_n = 1'b0;
        repeat (500) @(negedge core_clk);
        for (int i = 0; i < 32; i++) begin
            scl = 1'b1;
            q   = {q[30:0], miso};
            tick();
            scl = 1'b0;
            tick();
        end
        ss_n = 1'b1;
        tick();
    endtask
endmodule // pso_host_model

// >>> tb/test_pressure_sensor_output_port.sv
`timescale 1ns/100ps
module test_pressure_sensor_output_port;
    import pso_pkg::*;
    localparam int BOOT = 50;
    localparam int UPD  = 40;
    localparam logic [29:0] V1 = 30'h2BCD1234;
    localparam logic [29:0] V2 = 30'h15A50F0F;
    logic        core_clk, resetn, cfg_use_tw, cfg_sleep, cmd_mode_in;
    logic        diag_in, meas_done, meas_start, sda_out, sda_oe;
    logic        miso_out, miso_oe, int_ss_out, int_ss_oe, scl, sda_low, ss_n;
    logic [1:0]  cfg_rate, status;
    logic [29:0] meas_value;
    logic [31:0] pkt;
    logic [7:0]  q;
    logic        a;
    wire         sda_wire = ~(sda_low | (sda_oe & ~sda_out));
    int          fails, checked, conv_cnt, nstarts;

    pso_port #(.STARTUP_CYC(BOOT), .UPD0_CYC(UPD), .UPD1_CYC(UPD),
               .UPD2_CYC(UPD), .UPD3_CYC(UPD)) u_pso_port (
        .core_clk(core_clk), .resetn(resetn), .cfg_use_tw(cfg_use_tw),
        .cfg_sleep(cfg_sleep), .cfg_rate(cfg_rate),
        .cmd_mode_in(cmd_mode_in), .diag_in(diag_in),
        .meas_start(meas_start), .meas_done(meas_done),
        .meas_value(meas_value), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .miso_out(miso_out),
        .miso_oe(miso_oe), .int_ss_in(ss_n), .int_ss_out(int_ss_out),
        .int_ss_oe(int_ss_oe), .status(status));
    pso_host_model u_pso_host_model (.core_clk(core_clk),
        .sda_wire(sda_wire), .miso(miso_out), .scl(scl),
        .sda_low(sda_low), .ss_n(ss_n));

    always #2.5 core_clk = ~core_clk;
    // Converter stand-in: answers each start after ten cycles
    always @(negedge core_clk) begin
        meas_done <= (conv_cnt == 1);
        if (meas_start) begin
            conv_cnt <= 10;
            nstarts  <= nstarts + 1;
        end else if (conv_cnt > 0) begin
            conv_cnt <= conv_cnt - 1;
        end
    end

    task automatic give_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // Counts starts, so a pulse that came before the call is not missed
    task automatic wait_start(input int want, input int lim);
        int n;
        n = 0;
        while (nstarts < want && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (nstarts < want) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic tw_read(input int nb);
        pkt = '0;
        u_pso_host_model.hstart();
        u_pso_host_model.xfer({TGT_ADDR, 1'b1}, 1'b1, q, a);
        cmp(a, 0);
        for (int i = 0; i < nb; i++) begin
            u_pso_host_model.xfer(8'hFF, i == nb - 1, q, a);
            pkt = {pkt[23:0], q};
        end
        u_pso_host_model.hstop();
    endtask

    initial begin
        {core_clk, resetn, cmd_mode_in, diag_in, meas_done} = '0;
        {conv_cnt, nstarts, fails, checked} = '0;
        {cfg_use_tw, cfg_sleep, cfg_rate, meas_value} = {2'h3, 2'h0, V1};
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        repeat (3) @(negedge core_clk);
        cmp(status, ST_STALE);
        cmp(int_ss_oe, 1);
        repeat (BOOT + 10) @(negedge core_clk);
        tw_read(1);
        cmp(pkt[7:6], ST_STALE);
        cmp(nstarts, 0);
        u_pso_host_model.hstart();
        u_pso_host_model.xfer({TGT_ADDR, 1'b0}, 1'b1, q, a);
        cmp(a, 0);
        u_pso_host_model.xfer(8'hA5, 1'b1, q, a);
        u_pso_host_model.hstop();
        // The start pulse comes while the stop is still being sent
        wait_start(1, 200);
        repeat (20) @(negedge core_clk);
        cmp(int_ss_out, 1);
        cmp(status, ST_GOOD);
        tw_read(4);
        cmp(pkt, {ST_GOOD, V1});
        repeat (10) @(negedge core_clk);
        cmp(status, ST_STALE);
        cmp(int_ss_out, 0);
        u_pso_host_model.hstart();
        u_pso_host_model.xfer({7'h29, 1'b1}, 1'b1, q, a);
        u_pso_host_model.hstop();
        cmp(a, 1);
        diag_in = 1'b1;
        repeat (10) @(negedge core_clk);
        cmp(status, ST_DIAG);
        cmd_mode_in = 1'b1;
        repeat (10) @(negedge core_clk);
        cmp(status, ST_DIAG);
        diag_in = 1'b0;
        repeat (10) @(negedge core_clk);
        cmp(status, ST_CMD);
        cmd_mode_in = 1'b0;
        resetn = 1'b0;
        {cfg_use_tw, cfg_sleep, cfg_rate, meas_value} = {2'h0, 2'h1, V2};
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        wait_start(nstarts + 1, BOOT + 100);
        cmp(int_ss_oe, 0);
        // Straps are locked, so a late change must not switch the mode
        cfg_use_tw = 1'b1;
        repeat (30) @(negedge core_clk);
        cmp(int_ss_oe, 0);
        cmp(miso_oe, 0);
        u_pso_host_model.sread(pkt);
        cmp(pkt, {ST_GOOD, V2});
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        fails++;
        give_verdict();
    end
endmodule // test_pressure_sensor_output_port
